// >>> ises_defines.svh
// Opcodes, clock counts and lane codes for the interrupt-enable and string-store logic
`ifndef ISES_DEFINES_SVH
`define ISES_DEFINES_SVH

`define ISES_OP_SET_IRQ_EN   8'hfb
`define ISES_OP_CLR_IRQ_EN   8'hfa
`define ISES_OP_STORE_BYTE   8'haa
`define ISES_OP_STORE_WORD   8'hab
`define ISES_OP_TRAP_EXIT    8'hcf

`define ISES_SET_IRQ_EN_CLKS 2
`define ISES_STORE_BYTE_CLKS 10
`define ISES_STORE_WORD_CLKS 10
`define ISES_STORE_WORD_BYTE_BUS_CLKS 14

`define ISES_LANE_LOW  2'h1
`define ISES_LANE_HIGH 2'h2
`define ISES_LANE_BOTH 2'h3
`define ISES_SEG_SHIFT 4'h0

`endif

// >>> ises_exec.sv
// Executor for the interrupt-enable set and string-store instructions
`timescale 1ns/10ps
`include "ises_defines.svh"
module ises_exec #(
  parameter int BYTE_BUS = 0,
  parameter int N_SRC = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction stream
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic other_done,
  output logic op_ready,
  output logic op_done,
  output logic [7:0] op_done_code,
  // Architectural state
  input wire logic [15:0] accumulator_word,
  input wire logic [15:0] extra_segment_reg,
  input wire logic [15:0] target_index_reg,
  input wire logic string_direction_flag,
  input wire logic popped_irq_enable,
  output logic [15:0] target_index_out,
  output logic target_index_we,
  output logic irq_enable_flag,
  // Memory write path
  output logic mem_wr,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_data,
  output logic [1:0] mem_byte_en,
  // Maskable interrupts
  input wire logic [N_SRC-1:0] irq_req,
  input wire logic [N_SRC-1:0] irq_mask,
  input wire logic sw_int_entry,
  output logic irq_accept,
  output logic [N_SRC-1:0] irq_source
);
  localparam int STI_CLKS = `ISES_SET_IRQ_EN_CLKS;
  localparam int B_CLKS = `ISES_STORE_BYTE_CLKS;
  localparam int W_CLKS = (BYTE_BUS != 0) ? `ISES_STORE_WORD_BYTE_BUS_CLKS
                                          : `ISES_STORE_WORD_CLKS;
  generate
    if (N_SRC < 1 || N_SRC > 32 || STI_CLKS < 2 || B_CLKS < 2 || W_CLKS > 17) begin : g_chk
      $error("ises_exec: unsupported parameter values");
    end
  endgenerate
  function automatic logic [N_SRC-1:0] lowest_set(input logic [N_SRC-1:0] v);
    lowest_set = v & (~v + {{(N_SRC-1){1'b0}}, 1'b1});
  endfunction
  function automatic logic [3:0] load_count(input int clks);
    load_count = 4'(clks - 2);
  endfunction
  ises_store_if st ();
  ises_store_calc u_calc (
    .st(st)
  );
  assign st.target_index_reg = target_index_reg;
  assign st.extra_segment_reg = extra_segment_reg;
  assign st.string_direction_flag = string_direction_flag;
  assign st.word_op = op_code[0];
  ises_pkg::ises_state_type state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] cur_op, next_cur_op;
  logic [15:0] pend_index, next_pend_index;
  logic shadow, next_shadow;
  logic next_op_ready, next_op_done, next_index_we, next_irq_en, next_accept, next_mem_wr;
  logic [7:0] next_done_code;
  logic [15:0] next_index_out, next_mem_data;
  logic [19:0] next_mem_addr;
  logic [1:0] next_byte_en;
  logic [N_SRC-1:0] next_source, pending;
  logic take, done_now, is_store;
  assign take = (state == ises_pkg::ISES_IDLE) && op_valid;
  assign pending = irq_req & ~irq_mask;
  // Typed and operand-less forms share one opcode each
  assign is_store = (op_code == `ISES_OP_STORE_BYTE) || (op_code == `ISES_OP_STORE_WORD);
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur_op = cur_op;
    next_pend_index = pend_index;
    next_shadow = shadow;
    next_op_done = 1'b0;
    next_done_code = op_done_code;
    next_index_we = 1'b0;
    next_index_out = target_index_out;
    next_irq_en = irq_enable_flag;
    next_accept = 1'b0;
    next_source = '0;
    next_mem_wr = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_data = mem_data;
    next_byte_en = mem_byte_en;
    done_now = 1'b0;
    case (state)
      ises_pkg::ISES_IDLE: begin
        if (op_valid) begin
          next_cur_op = op_code;
          if (op_code == `ISES_OP_SET_IRQ_EN) begin
            next_state = ises_pkg::ISES_EXEC;
            next_cnt = load_count(STI_CLKS);
          end else if (is_store) begin
            next_state = ises_pkg::ISES_EXEC;
            next_mem_wr = 1'b1;
            next_mem_addr = st.phys_addr;
            next_pend_index = st.next_index;
            if (op_code[0]) begin
              next_cnt = load_count(W_CLKS);
              next_mem_data = accumulator_word;
              next_byte_en = `ISES_LANE_BOTH;
            end else begin
              next_cnt = load_count(B_CLKS);
              next_mem_data = {accumulator_word[7:0], accumulator_word[7:0]};
              next_byte_en = st.phys_addr[0] ? `ISES_LANE_HIGH : `ISES_LANE_LOW;
            end
          end else begin
            next_state = ises_pkg::ISES_FOREIGN;
          end
        end else if (irq_enable_flag && !shadow && (|pending)) begin
          next_accept = 1'b1;
          next_source = lowest_set(pending);
          next_irq_en = 1'b0;
        end
      end
      ises_pkg::ISES_EXEC: begin
        if (cnt == 4'h0) begin
          done_now = 1'b1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      ises_pkg::ISES_FOREIGN: begin
        done_now = other_done;
      end
      default: begin
        next_state = ises_pkg::ISES_IDLE;
      end
    endcase
    if (done_now) begin
      next_state = ises_pkg::ISES_IDLE;
      next_op_done = 1'b1;
      next_done_code = cur_op;
      // Only the enable flag is owned here; status flags pass untouched
      case (cur_op)
        `ISES_OP_SET_IRQ_EN: next_irq_en = 1'b1;
        `ISES_OP_CLR_IRQ_EN: next_irq_en = 1'b0;
        `ISES_OP_TRAP_EXIT: next_irq_en = popped_irq_enable;
        `ISES_OP_STORE_BYTE, `ISES_OP_STORE_WORD: begin
          next_index_we = 1'b1;
          next_index_out = pend_index;
        end
        default: next_irq_en = irq_enable_flag;
      endcase
      // Recognition waits one boundary after the set, and honours a following clear
      next_shadow = (cur_op == `ISES_OP_SET_IRQ_EN);
      if (cur_op != `ISES_OP_SET_IRQ_EN && next_irq_en && (|pending)) begin
        next_accept = 1'b1;
        next_source = lowest_set(pending);
        next_irq_en = 1'b0;
      end
    end
    // Software entry runs outside; here it only clears the enable flag
    if (sw_int_entry) begin
      next_irq_en = 1'b0;
    end
    next_op_ready = (next_state == ises_pkg::ISES_IDLE);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ises_pkg::ISES_IDLE;
      cnt <= 4'h0;
      cur_op <= 8'h00;
      pend_index <= 16'h0000;
      shadow <= 1'b0;
      op_ready <= 1'b1;
      op_done <= 1'b0;
      op_done_code <= 8'h00;
      target_index_we <= 1'b0;
      target_index_out <= 16'h0000;
      irq_enable_flag <= 1'b0;
      irq_accept <= 1'b0;
      irq_source <= '0;
      mem_wr <= 1'b0;
      mem_addr <= 20'h00000;
      mem_data <= 16'h0000;
      mem_byte_en <= 2'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur_op <= next_cur_op;
      pend_index <= next_pend_index;
      shadow <= next_shadow;
      op_ready <= next_op_ready;
      op_done <= next_op_done;
      op_done_code <= next_done_code;
      target_index_we <= next_index_we;
      target_index_out <= next_index_out;
      irq_enable_flag <= next_irq_en;
      irq_accept <= next_accept;
      irq_source <= next_source;
      mem_wr <= next_mem_wr;
      mem_addr <= next_mem_addr;
      mem_data <= next_mem_data;
      mem_byte_en <= next_byte_en;
    end
  end

  // Checking
  logic [15:0] chk_index;
  logic chk_dir, chk_word;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chk_index <= 16'h0000;
      chk_dir <= 1'b0;
      chk_word <= 1'b0;
    end else if (take && is_store) begin
      chk_index <= target_index_reg;
      chk_dir <= string_direction_flag;
      chk_word <= op_code[0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take_store_byte;
    take && op_code == `ISES_OP_STORE_BYTE;
  endsequence
  sequence s_take_store_word;
    take && op_code == `ISES_OP_STORE_WORD;
  endsequence
  property p_sti_sets_flag;
    take && op_code == `ISES_OP_SET_IRQ_EN |-> ##STI_CLKS (op_done && irq_enable_flag);
  endproperty
  a_sti_sets_flag: assert property (p_sti_sets_flag) else $error("set-enable failed");
  property p_sti_no_accept;
    op_done && op_done_code == `ISES_OP_SET_IRQ_EN |-> !irq_accept;
  endproperty
  a_sti_no_accept: assert property (p_sti_no_accept) else $error("accept after set");
  // A trap exit may restore the flag and accept at its own boundary
  property p_accept_at_boundary;
    irq_accept |-> op_done || ($past(op_ready) && $past(irq_enable_flag));
  endproperty
  a_accept_at_boundary: assert property (p_accept_at_boundary) else $error("mid-op accept");
  property p_clear_blocks;
    op_done && op_done_code == `ISES_OP_CLR_IRQ_EN |-> !irq_accept && !irq_enable_flag;
  endproperty
  a_clear_blocks: assert property (p_clear_blocks) else $error("accept across clear");
  property p_masked_blocked;
    irq_accept |-> (irq_source & $past(irq_mask)) == '0 && irq_source != '0 && !irq_enable_flag;
  endproperty
  a_masked_blocked: assert property (p_masked_blocked) else $error("masked source taken");
  property p_sw_entry_clears;
    sw_int_entry |=> !irq_enable_flag;
  endproperty
  a_sw_entry_clears: assert property (p_sw_entry_clears) else $error("entry left flag");
  property p_trap_restores;
    op_done && op_done_code == `ISES_OP_TRAP_EXIT && !irq_accept && !$past(sw_int_entry)
      |-> irq_enable_flag == $past(popped_irq_enable);
  endproperty
  a_trap_restores: assert property (p_trap_restores) else $error("exit restore wrong");
  property p_store_byte;
    s_take_store_byte |=> mem_wr && mem_byte_en != `ISES_LANE_BOTH
      ##(B_CLKS - 1) (op_done && target_index_we);
  endproperty
  a_store_byte: assert property (p_store_byte) else $error("byte store timing");
  property p_store_word;
    s_take_store_word |=> mem_wr && mem_byte_en == `ISES_LANE_BOTH
      && mem_data == $past(accumulator_word) ##(W_CLKS - 1) (op_done && target_index_we);
  endproperty
  a_store_word: assert property (p_store_word) else $error("word store timing");
  property p_extra_segment;
    mem_wr |-> mem_addr == {$past(extra_segment_reg), `ISES_SEG_SHIFT}
                           + {4'h0, $past(target_index_reg)};
  endproperty
  a_extra_segment: assert property (p_extra_segment) else $error("bad store address");
  property p_index_step;
    target_index_we |-> target_index_out == (chk_dir ? chk_index - (chk_word ? 16'h0002 : 16'h0001)
                                                     : chk_index + (chk_word ? 16'h0002 : 16'h0001));
  endproperty
  a_index_step: assert property (p_index_step) else $error("index step wrong");
endmodule

// >>> ises_mem_model.sv
// Partner model: memory write path and level-held interrupt sources
`timescale 1ns/10ps
module ises_mem_model #(
  parameter int N_SRC = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Memory write path
  input wire logic mem_wr,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_data,
  input wire logic [1:0] mem_byte_en,
  output logic [19:0] wr_addr,
  output logic [15:0] wr_data,
  output logic [1:0] wr_be,
  output int wr_count,
  // Interrupt sources
  input wire logic [N_SRC-1:0] raise,
  input wire logic irq_accept,
  input wire logic [N_SRC-1:0] irq_source,
  output logic [N_SRC-1:0] irq_req,
  output logic [N_SRC-1:0] acc_src,
  output int acc_count
);
  // Requests stay up until acknowledged, as a real source line would
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_be <= '0;
      wr_count <= 0;
      irq_req <= '0;
      acc_src <= '0;
      acc_count <= 0;
    end else begin
      if (mem_wr) begin
        wr_addr <= mem_addr;
        wr_data <= mem_data;
        wr_be <= mem_byte_en;
        wr_count <= wr_count + 1;
      end
      irq_req <= (irq_req | raise) & ~(irq_accept ? irq_source : '0);
      if (irq_accept) begin
        acc_src <= irq_source;
        acc_count <= acc_count + 1;
      end
    end
  end
endmodule

// >>> ises_pkg.sv
// Types shared by the interrupt-enable and string-store logic
package ises_pkg;
  typedef enum logic [1:0] {
    ISES_IDLE,
    ISES_EXEC,
    ISES_FOREIGN
  } ises_state_type;
endpackage

// >>> ises_store_calc.sv
// String-store destination address and index step
`timescale 1ns/10ps
`include "ises_defines.svh"
module ises_store_calc (
  // Operands and results
  ises_store_if.calc st
);
  // Step wraps in 16 bits; the segment register is only read
  function automatic logic [15:0] ises_step(input logic [15:0] idx, input logic dir,
                                            input logic word);
    logic [15:0] delta;
    delta = word ? 16'h0002 : 16'h0001;
    ises_step = dir ? idx - delta : idx + delta;
  endfunction

  // Always the extra segment; no override path exists
  assign st.phys_addr = {st.extra_segment_reg, `ISES_SEG_SHIFT}
                        + {4'h0, st.target_index_reg};
  assign st.next_index = ises_step(st.target_index_reg, st.string_direction_flag, st.word_op);
endmodule

// >>> ises_store_if.sv
// Carrier between the executor and the string-store address unit
`timescale 1ns/10ps
interface ises_store_if;
  logic [15:0] target_index_reg;
  logic [15:0] extra_segment_reg;
  logic string_direction_flag;
  logic word_op;
  logic [19:0] phys_addr;
  logic [15:0] next_index;
  modport calc (
    input target_index_reg,
    input extra_segment_reg,
    input string_direction_flag,
    input word_op,
    output phys_addr,
    output next_index
  );
  modport core (
    output target_index_reg,
    output extra_segment_reg,
    output string_direction_flag,
    output word_op,
    input phys_addr,
    input next_index
  );
endinterface

// >>> tb.sv
// Testbench for the interrupt-enable and string-store executor
`timescale 1ns/10ps
`include "ises_defines.svh"
module tb;
  logic sys_clk, rst, op_valid, other_done, string_direction_flag, popped_irq_enable;
  logic sw_int_entry, op_ready, op_done, target_index_we, irq_enable_flag, mem_wr, irq_accept;
  logic [7:0] op_code, op_done_code, irq_req, irq_mask, irq_source, raise, acc_src;
  logic [15:0] accumulator_word, extra_segment_reg, target_index_reg, target_index_out;
  logic [15:0] mem_data, wr_data;
  logic [19:0] mem_addr, wr_addr;
  logic [1:0] mem_byte_en, wr_be;
  int failures, cmp_count, cyc, wr_count, acc_count, n, a0;
  logic op_valid_bb, op_done_bb;

  ises_exec #(.BYTE_BUS(0), .N_SRC(8)) DUT (.sys_clk(sys_clk), .rst(rst),
    .op_valid(op_valid), .op_code(op_code), .other_done(other_done), .op_ready(op_ready),
    .op_done(op_done), .op_done_code(op_done_code), .accumulator_word(accumulator_word),
    .extra_segment_reg(extra_segment_reg), .target_index_reg(target_index_reg),
    .string_direction_flag(string_direction_flag), .popped_irq_enable(popped_irq_enable),
    .target_index_out(target_index_out), .target_index_we(target_index_we),
    .irq_enable_flag(irq_enable_flag), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_byte_en(mem_byte_en), .irq_req(irq_req), .irq_mask(irq_mask),
    .sw_int_entry(sw_int_entry), .irq_accept(irq_accept), .irq_source(irq_source));

  // Byte-bus variant: only ever offered one word store, so its flag stays clear
  ises_exec #(.BYTE_BUS(1), .N_SRC(8)) DUT_BB (.sys_clk(sys_clk), .rst(rst),
    .op_valid(op_valid_bb), .op_code(op_code), .other_done(other_done), .op_ready(),
    .op_done(op_done_bb), .op_done_code(), .accumulator_word(accumulator_word),
    .extra_segment_reg(extra_segment_reg), .target_index_reg(target_index_reg),
    .string_direction_flag(string_direction_flag), .popped_irq_enable(popped_irq_enable),
    .target_index_out(), .target_index_we(), .irq_enable_flag(), .mem_wr(), .mem_addr(),
    .mem_data(), .mem_byte_en(), .irq_req(irq_req), .irq_mask(irq_mask),
    .sw_int_entry(sw_int_entry), .irq_accept(), .irq_source());

  ises_mem_model #(.N_SRC(8)) partner (.sys_clk(sys_clk), .rst(rst), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_byte_en(mem_byte_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_be(wr_be), .wr_count(wr_count), .raise(raise),
    .irq_accept(irq_accept), .irq_source(irq_source), .irq_req(irq_req), .acc_src(acc_src),
    .acc_count(acc_count));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is under two hundred cycles; the 2000-cycle limit lies far above it
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      stop_test;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Foreign ops get their completion pulse a few cycles after the take
  task run_op(input logic [7:0] c, input logic fire, output int k);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= c;
    k = 0;
    do begin
      @(posedge sys_clk);
      if (k == 0) op_valid <= 1'b0;
      other_done <= fire && (k == 2);
      k++;
      #1;
    end while (op_done !== 1'b1 && k < 40);
  endtask

  task do_store(input logic w, input logic df, input logic [15:0] es, input logic [15:0] di,
                input logic ief);
    int k, w0;
    logic [19:0] a;
    logic [15:0] ax, st;
    a = {es, 4'h0} + {4'h0, di};
    ax = 16'ha55a ^ di;
    st = w ? 16'h0002 : 16'h0001;
    w0 = wr_count;
    @(posedge sys_clk);
    accumulator_word <= ax;
    extra_segment_reg <= es;
    target_index_reg <= di;
    string_direction_flag <= df;
    run_op(w ? `ISES_OP_STORE_WORD : `ISES_OP_STORE_BYTE, 1'b0, k);
    chk(k, w ? `ISES_STORE_WORD_CLKS : `ISES_STORE_BYTE_CLKS);
    chk(wr_count - w0, 1);
    chk(wr_addr, a);
    chk(wr_data, w ? ax : {ax[7:0], ax[7:0]});
    chk(wr_be, w ? 2'h3 : (a[0] ? 2'h2 : 2'h1));
    chk(target_index_we, 1'b1);
    chk(target_index_out, df ? 16'(di - st) : 16'(di + st));
    chk(irq_enable_flag, ief);
  endtask

  initial begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_valid_bb = 1'b0;
    op_code = 8'h00;
    other_done = 1'b0;
    accumulator_word = 16'h0000;
    extra_segment_reg = 16'h0000;
    target_index_reg = 16'h0000;
    string_direction_flag = 1'b0;
    popped_irq_enable = 1'b0;
    sw_int_entry = 1'b0;
    irq_mask = 8'h00;
    raise = 8'h00;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk({op_ready, irq_enable_flag, mem_wr}, 3'h4);
    // Index wrap at both ends, 20-bit address wrap, both lanes
    do_store(1'b0, 1'b0, 16'h2000, 16'hffff, 1'b0);
    do_store(1'b1, 1'b1, 16'hffff, 16'h0010, 1'b0);
    do_store(1'b0, 1'b1, 16'h0000, 16'h0000, 1'b0);
    do_store(1'b1, 1'b0, 16'h1000, 16'hfffe, 1'b0);
    // Pending source 3, masked source 1; foreign op 8'hc3 follows the enable
    @(posedge sys_clk);
    irq_mask <= 8'h02;
    raise <= 8'h0a;
    @(posedge sys_clk);
    raise <= 8'h00;
    a0 = acc_count;
    run_op(`ISES_OP_SET_IRQ_EN, 1'b0, n);
    chk(n, `ISES_SET_IRQ_EN_CLKS);
    chk({irq_enable_flag, irq_accept}, 2'h2);
    run_op(8'hc3, 1'b1, n);
    chk({op_done_code, irq_accept}, {8'hc3, 1'b1});
    chk(acc_count - a0, 0);
    chk(irq_source, 8'h08);
    chk(irq_enable_flag, 1'b0);
    // Enable then clear: nothing slips in
    @(posedge sys_clk);
    raise <= 8'h10;
    @(posedge sys_clk);
    raise <= 8'h00;
    a0 = acc_count;
    run_op(`ISES_OP_SET_IRQ_EN, 1'b0, n);
    run_op(`ISES_OP_CLR_IRQ_EN, 1'b1, n);
    repeat (5) @(posedge sys_clk);
    #1;
    chk(acc_count - a0, 0);
    chk(irq_enable_flag, 1'b0);
    // All sources masked: flag stays up, stores leave it alone
    @(posedge sys_clk);
    irq_mask <= 8'hff;
    run_op(`ISES_OP_SET_IRQ_EN, 1'b0, n);
    run_op(8'h90, 1'b1, n);
    chk({irq_accept, irq_enable_flag}, 2'h1);
    do_store(1'b1, 1'b1, 16'h1234, 16'h0000, 1'b1);
    do_store(1'b0, 1'b0, 16'h0abc, 16'h0101, 1'b1);
    chk(acc_count - a0, 0);
    @(posedge sys_clk);
    sw_int_entry <= 1'b1;
    @(posedge sys_clk);
    sw_int_entry <= 1'b0;
    #1;
    chk(irq_enable_flag, 1'b0);
    popped_irq_enable <= 1'b1;
    run_op(`ISES_OP_TRAP_EXIT, 1'b1, n);
    #20;
    chk(irq_enable_flag, 1'b1);
    // Unmask source 4 only; idle acceptance picks it up
    @(posedge sys_clk);
    irq_mask <= 8'hef;
    for (int i = 0; i < 8 && acc_count == a0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(acc_count - a0, 1);
    chk(acc_src, 8'h10);
    // Byte-bus variant: word store takes the longer count
    @(posedge sys_clk);
    op_code <= `ISES_OP_STORE_WORD;
    op_valid_bb <= 1'b1;
    @(posedge sys_clk);
    op_valid_bb <= 1'b0;
    n = 1;
    while (op_done_bb !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
      #1;
    end
    chk(n, `ISES_STORE_WORD_BYTE_BUS_CLKS);
    stop_test;
  end
endmodule
